/* File: logic/ctsl_core.sv */
// Tag control core: link framing, state machine, locks, anticollision
//
// What this block does
// - Settings block write only clears bits
// - All-zero settings block refuses further updates
// - Lock bits 31..24 protect user blocks 7..15
// - Lock bits never return to one
// - Fixed identifier option disables random identifier
// - Characters are 10 bits, start bit first
// - Bad command or CRC: discard, no reply
// - Replies framed, end with two CRC bytes
// - No field, no response at all
// - Power-up: reset, random identifier, Ready, wake only
// - Wake enters Inventory; anticollision answered there
// - Matching select moves Inventory to Selected
// - Selected runs memory commands, ignores anticollision
// - Selected: other select deselects, completion deactivates
// - Deselected: only matching select returns to Selected
// - Deactivated ignores everything until power loss
// - Wake answered at once; poll has 16 slots
// - New random identifier in Ready and on wake
// - Slot number is identifier bits 3..0
// - Answer at most once per anticollision sequence
// - Poll draws new slot; zero slot answers
// - Slot advance answers only on matching slot
`timescale 1ns/1ps
`default_nettype none
`include "ctsl_consts.svh"
module ctsl_core
	import ctsl_pkg::*;
#(
	parameter logic        FIXED_ID_EN = 1'b0,
	parameter logic [31:0] SYS_INIT    = `CTSL_SYS_RESET,
	// Arbitrary value, no meaning
	parameter logic [63:0] UNIQUE_ID   = 64'h0123_4567_89ab_cdef,
	parameter int          FIFO_DEPTH  = 8
)
(
	input  wire logic            i_clk,
	input  wire logic            i_resetn,
	input  wire logic            i_field_ok,
	input  wire ctsl_link_s      i_link,
	output var  logic            o_link_tx,
	output var  logic            o_link_tx_frame,
	output var  logic            o_mem_req,
	output var  ctsl_mem_req_s   o_mem,
	input  wire logic            i_mem_ack,
	input  wire logic [31:0]     i_mem_rdata,
	output logic [2:0]           o_tag_state,
	output logic [7:0]           o_tag_session_identifier
);

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ `CTSL_CRC_POLY) : (r >> 1);
		return r;
	endfunction : crc_byte

	function automatic logic blk_locked(input logic [7:0] a,
		input logic [31:0] s);
		logic pair;
		logic single;
		pair   = (a == `CTSL_BLK_PAIR_A) | (a == `CTSL_BLK_PAIR_B);
		single = (a >= `CTSL_BLK_SINGLE_LO) & (a <= `CTSL_BLK_SINGLE_HI);
		return (pair & ~s[`CTSL_LOCK_LSB]) |
			(single & ~s[{2'b11, a[2:0]}]);
	endfunction : blk_locked

	ctsl_link_s      lk_s1;
	ctsl_link_s      lk_s2;
	ctsl_link_s      lk_s3;
	logic            fld_s1;
	logic            fld_s2;
	ctsl_tag_state_e tag_st;
	ctsl_tag_state_e next_tag_st;
	ctsl_ctl_e       ctl;
	logic [31:0]     sys;
	logic [7:0]      id;
	logic [7:0]      next_id;
	logic [7:0]      lfsr;
	logic            answered;
	logic [9:0]      rx_sh;
	logic [3:0]      rx_cnt;
	logic            rx_bad;
	logic [63:0]     rx_buf;
	logic [3:0]      rx_len;
	logic [15:0]     rx_crc;
	logic            pr_bad;
	logic            end_pend;
	logic [63:0]     tx_buf;
	logic [3:0]      tx_len;
	logic [3:0]      tx_idx;
	logic [3:0]      tx_bit;
	logic [9:0]      tx_sh;
	logic [15:0]     tx_crc;
	logic            f_in_ready;
	logic            f_out_valid;
	logic [7:0]      f_out_data;
	logic            f_pop;

	// Link pins come from the reader's clock; two flops before use
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			lk_s1  <= '0;
			lk_s2  <= '0;
			lk_s3  <= '0;
			fld_s1 <= 1'b0;
			fld_s2 <= 1'b0;
		end
		else
		begin
			lk_s1  <= i_link;
			lk_s2  <= lk_s1;
			lk_s3  <= lk_s2;
			fld_s1 <= i_field_ok;
			fld_s2 <= fld_s1;
		end
	end

	wire logic lk_rise = lk_s2.clk & ~lk_s3.clk;
	wire logic lk_fall = ~lk_s2.clk & lk_s3.clk;
	wire logic fr_rise = lk_s2.frame & ~lk_s3.frame;
	wire logic fr_fall = ~lk_s2.frame & lk_s3.frame;

	// Receive characters, start bit first, stop bit last
	wire logic [9:0] rx_next    = {lk_s2.data, rx_sh[9:1]};
	wire logic       rx_bit     = lk_rise & lk_s2.frame;
	wire logic       rx_char    = rx_bit & (rx_cnt == `CTSL_CHAR_LAST);
	wire logic       rx_char_ok = ~rx_next[0] & rx_next[9];
	wire logic       f_push     = rx_char & rx_char_ok;

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || fr_rise)
		begin
			rx_sh  <= '0;
			rx_cnt <= '0;
			rx_bad <= 1'b0;
		end
		else if (rx_bit)
		begin
			rx_sh  <= rx_next;
			rx_cnt <= rx_char ? 4'h0 : rx_cnt + 4'h1;
			// Air link cannot be stalled: a full FIFO spoils the frame
			if (rx_char && (!rx_char_ok || !f_in_ready))
				rx_bad <= 1'b1;
		end
	end

	ctsl_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_valid  (f_push),
		.o_ready  (f_in_ready),
		.i_data   (rx_next[8:1]),
		.o_valid  (f_out_valid),
		.i_ready  (f_pop),
		.o_data   (f_out_data)
	);

	// Parser stalls while busy, so buffered bytes back up
	assign f_pop = f_out_valid & (ctl == CTSL_IDLE);
	wire logic frame_take = end_pend & ~f_out_valid & (ctl == CTSL_IDLE);
	wire logic crc_good   = (rx_crc == `CTSL_CRC_GOOD);
	wire logic frame_go   = frame_take & ~rx_bad & ~pr_bad & crc_good &
		(rx_len >= `CTSL_MIN_FRAME) & fld_s2 &
		(tag_st != CTSL_POWER_OFF);

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || frame_take)
		begin
			rx_len   <= '0;
			rx_crc   <= `CTSL_CRC_INIT;
			pr_bad   <= 1'b0;
			end_pend <= 1'b0;
		end
		else
		begin
			if (fr_fall)
				end_pend <= 1'b1;
			if (f_pop)
			begin
				rx_crc <= crc_byte(rx_crc, f_out_data);
				if (rx_len[3])
					pr_bad <= 1'b1;
				else
					rx_len <= rx_len + 4'h1;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (f_pop && !rx_len[3])
			rx_buf[{rx_len[2:0], 3'h0} +: 8] <= f_out_data;
	end

	// Command decode; unknown codes match nothing and are dropped
	wire logic [7:0]  cmd      = rx_buf[7:0];
	wire logic [7:0]  arg      = rx_buf[15:8];
	wire logic [3:0]  plen     = rx_len - `CTSL_CRC_LEN;
	wire logic [31:0] wdata    = rx_buf[47:16];
	wire logic        is_wake  = (cmd == `CTSL_CMD_WAKE);
	wire logic        is_poll  = (cmd == `CTSL_CMD_POLL);
	wire logic        is_adv   = (cmd[3:0] == `CTSL_CMD_ADV_LO);
	wire logic        is_sel   = (cmd == `CTSL_CMD_SELECT) & (plen >= 4'h2);
	wire logic        is_read  = (cmd == `CTSL_CMD_READ) & (plen >= 4'h2);
	wire logic        is_write = (cmd == `CTSL_CMD_WRITE) & (plen == 4'h6);
	wire logic        is_uid   = (cmd == `CTSL_CMD_UID);
	wire logic        is_done  = (cmd == `CTSL_CMD_DONE);
	wire logic        id_match = (arg == id);
	wire logic        to_sys   = (arg == `CTSL_SYS_ADDR);
	wire logic        in_ready = (tag_st == CTSL_READY);
	wire logic        in_inv   = (tag_st == CTSL_INVENTORY);
	wire logic        in_sel   = (tag_st == CTSL_SELECTED);
	wire logic        locked   = blk_locked(arg, sys);

	wire logic ans_wake = frame_go & is_wake & (in_ready | in_inv);
	wire logic ans_poll = frame_go & in_inv & is_poll & ~answered &
		(next_id[3:0] == 4'h0);
	wire logic ans_adv  = frame_go & in_inv & is_adv & ~answered &
		(cmd[7:4] == id[3:0]);
	wire logic ans_sel  = frame_go & is_sel & id_match &
		(in_inv | in_sel | (tag_st == CTSL_DESELECTED));
	wire logic go_uid   = frame_go & in_sel & is_uid;
	wire logic go_sysrd = frame_go & in_sel & is_read & to_sys;
	wire logic go_memrd = frame_go & in_sel & is_read & ~to_sys;
	wire logic go_memwr = frame_go & in_sel & is_write & ~to_sys &
		~locked;
	wire logic go_syswr = frame_go & in_sel & is_write & to_sys &
		(sys != 32'h0000_0000);
	wire logic go_id    = ans_wake | ans_poll | ans_adv | ans_sel;

	wire logic [63:0] ld_data = go_uid ? UNIQUE_ID :
		go_sysrd ? {32'h0000_0000, sys} : {56'h0, next_id};
	wire logic [3:0]  ld_len  = go_uid ? 4'h8 : go_sysrd ? 4'h4 : 4'h1;

	always_comb
	begin
		next_tag_st = tag_st;
		if (!fld_s2)
			next_tag_st = CTSL_POWER_OFF;
		else if (tag_st == CTSL_POWER_OFF)
			next_tag_st = CTSL_READY;
		else if (frame_go)
		begin
			case (tag_st)
				CTSL_READY:
					if (is_wake)
						next_tag_st = CTSL_INVENTORY;
				CTSL_INVENTORY:
					if (is_sel && id_match)
						next_tag_st = CTSL_SELECTED;
				CTSL_SELECTED:
					if (is_sel && !id_match)
						next_tag_st = CTSL_DESELECTED;
					else if (is_done)
						next_tag_st = CTSL_DEACTIVATED;
				CTSL_DESELECTED:
					if (is_sel && id_match)
						next_tag_st = CTSL_SELECTED;
				CTSL_DEACTIVATED:
					next_tag_st = CTSL_DEACTIVATED;
				default:
					next_tag_st = CTSL_READY;
			endcase
		end
	end

	always_comb
	begin
		next_id = id;
		if (FIXED_ID_EN)
			next_id = sys[7:0];
		else if (in_ready)
			next_id = lfsr;
		else if (frame_go && in_inv && is_wake)
			next_id = lfsr;
		else if (frame_go && in_inv && is_poll)
			next_id = {id[7:4], lfsr[3:0]};
	end

	// Free-running source; reader timing gives the spread between tags
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			lfsr     <= `CTSL_LFSR_SEED;
			tag_st   <= CTSL_READY;
			id       <= `CTSL_LFSR_SEED;
			answered <= 1'b0;
		end
		else
		begin
			lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
			tag_st   <= next_tag_st;
			id       <= next_id;
			if (ans_wake || !fld_s2)
				answered <= 1'b0;
			if (ans_poll || ans_adv)
				answered <= 1'b1;
		end
	end

	// Stands in for the one-time cells, loaded at power-up
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			sys <= SYS_INIT;
		else if (go_syswr)
			sys <= sys & wdata;
	end

	// Memory access and reply transmission
	wire logic [7:0] tx_byte = (tx_idx < tx_len) ?
		tx_buf[{tx_idx[2:0], 3'h0} +: 8] :
		(tx_idx == tx_len) ? ~tx_crc[7:0] : ~tx_crc[15:8];
	wire logic tx_done = (tx_idx == tx_len + `CTSL_CRC_LEN);
	wire logic tx_step = (ctl == CTSL_TX) & lk_fall;

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !fld_s2)
		begin
			ctl             <= CTSL_IDLE;
			o_link_tx       <= 1'b1;
			o_link_tx_frame <= 1'b0;
			o_mem_req       <= 1'b0;
			o_mem           <= '0;
			tx_buf          <= '0;
			tx_len          <= '0;
			tx_idx          <= '0;
			tx_bit          <= '0;
			tx_sh           <= '1;
			tx_crc          <= `CTSL_CRC_INIT;
		end
		else
		begin
			case (ctl)
				CTSL_IDLE:
					if (go_id || go_uid || go_sysrd)
					begin
						tx_buf          <= ld_data;
						tx_len          <= ld_len;
						tx_idx          <= 4'h0;
						tx_bit          <= `CTSL_CHAR_LAST;
						tx_crc          <= `CTSL_CRC_INIT;
						o_link_tx_frame <= 1'b1;
						ctl             <= CTSL_TX;
					end
					else if (go_memrd || go_memwr)
					begin
						o_mem_req <= 1'b1;
						o_mem     <= '{we: go_memwr, addr: arg, wdata: wdata};
						ctl       <= CTSL_MEM;
					end
				CTSL_MEM:
					if (i_mem_ack)
					begin
						o_mem_req <= 1'b0;
						if (o_mem.we)
							ctl <= CTSL_IDLE;
						else
						begin
							tx_buf          <= {32'h0000_0000, i_mem_rdata};
							tx_len          <= 4'h4;
							tx_idx          <= 4'h0;
							tx_bit          <= `CTSL_CHAR_LAST;
							tx_crc          <= `CTSL_CRC_INIT;
							o_link_tx_frame <= 1'b1;
							ctl             <= CTSL_TX;
						end
					end
				CTSL_TX:
					if (tx_step)
					begin
						if (tx_bit != `CTSL_CHAR_LAST)
						begin
							o_link_tx <= tx_sh[tx_bit + 4'h1];
							tx_bit    <= tx_bit + 4'h1;
						end
						else if (tx_done)
						begin
							o_link_tx       <= 1'b1;
							o_link_tx_frame <= 1'b0;
							ctl             <= CTSL_IDLE;
						end
						else
						begin
							tx_sh     <= {1'b1, tx_byte, 1'b0};
							o_link_tx <= 1'b0;
							tx_bit    <= 4'h0;
							tx_idx    <= tx_idx + 4'h1;
							if (tx_idx < tx_len)
								tx_crc <= crc_byte(tx_crc, tx_byte);
						end
					end
				default:
					ctl <= CTSL_IDLE;
			endcase
		end
	end

	assign o_tag_state              = tag_st;
	assign o_tag_session_identifier = id;

	a_wake_to_inv: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		frame_go && in_ready && is_wake && fld_s2 |=>
		tag_st == CTSL_INVENTORY)
		else $error("wake in ready did not reach inventory");

	a_ready_ignores: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		frame_go && in_ready && !is_wake && fld_s2 |=>
		tag_st == CTSL_READY && ctl == CTSL_IDLE)
		else $error("ready state acted on a non-wake command");

	a_select_match: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		frame_go && in_inv && is_sel && id_match && fld_s2 |=>
		tag_st == CTSL_SELECTED)
		else $error("matching select left tag unselected");

	a_deact_holds: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		tag_st == CTSL_DEACTIVATED && fld_s2 |=>
		tag_st == CTSL_DEACTIVATED && !o_link_tx_frame)
		else $error("deactivated tag changed state or answered");

	a_lock_monotone: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		1'b1 |=> (sys & ~$past(sys)) == 32'h0000_0000)
		else $error("settings bit returned from zero to one");

	a_bad_silent: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		frame_take && !crc_good |=> ctl == CTSL_IDLE ##1
		ctl == CTSL_IDLE && !o_link_tx_frame)
		else $error("frame with bad check caused activity");

	a_field_silent: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		!fld_s2 |=> !o_link_tx_frame && !o_mem_req &&
		tag_st == CTSL_POWER_OFF)
		else $error("tag active without field");

	a_answer_once: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		frame_go && answered && in_inv && (is_poll || is_adv) |=>
		ctl == CTSL_IDLE)
		else $error("tag answered twice in one sequence");

	a_adv_match: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		frame_go && in_inv && is_adv && fld_s2 |=>
		(ctl == CTSL_TX) == ($past(!answered) &&
		$past(cmd[7:4]) == $past(id[3:0])))
		else $error("slot advance answer does not follow slot match");

	a_no_locked_write: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		$rose(o_mem_req) && o_mem.we |->
		!blk_locked(o_mem.addr, sys))
		else $error("write issued to a protected block");

endmodule : ctsl_core
`default_nettype wire

/* File: logic/ctsl_consts.svh */
// Constants of the contactless tag control core
`ifndef CTSL_CONSTS_SVH
`define CTSL_CONSTS_SVH

// Settings block location and fields
`define CTSL_SYS_ADDR       8'hff
`define CTSL_SYS_RESET      32'hffff_ffff
`define CTSL_LOCK_LSB       5'h18
`define CTSL_BLK_PAIR_A     8'h07
`define CTSL_BLK_PAIR_B     8'h08
`define CTSL_BLK_SINGLE_LO  8'h09
`define CTSL_BLK_SINGLE_HI  8'h0f

// Character framing
`define CTSL_CHAR_LAST      4'h9
`define CTSL_MIN_FRAME      4'h3
`define CTSL_CRC_LEN        4'h2

// Frame check
`define CTSL_CRC_INIT       16'hffff
`define CTSL_CRC_POLY       16'h8408
`define CTSL_CRC_GOOD       16'hf0b8

// Command codes
`define CTSL_CMD_WAKE       8'h10
`define CTSL_CMD_POLL       8'h11
`define CTSL_CMD_ADV_LO     4'h6
`define CTSL_CMD_SELECT     8'h0e
`define CTSL_CMD_READ       8'h08
`define CTSL_CMD_WRITE      8'h09
`define CTSL_CMD_AUTH       8'h0a
`define CTSL_CMD_UID        8'h0b
`define CTSL_CMD_DONE       8'h0f

// Random source seed, any non-zero value
`define CTSL_LFSR_SEED      8'h5a

`endif

/* File: logic/ctsl_pkg.sv */
// Types shared by the contactless tag control core
`default_nettype none
package ctsl_pkg;

	typedef enum logic [2:0] {
		CTSL_READY       = 3'h0,
		CTSL_INVENTORY   = 3'h1,
		CTSL_SELECTED    = 3'h3,
		CTSL_DESELECTED  = 3'h2,
		CTSL_DEACTIVATED = 3'h6,
		CTSL_POWER_OFF   = 3'h4
	} ctsl_tag_state_e;

	typedef enum logic [1:0] {
		CTSL_IDLE = 2'h0,
		CTSL_MEM  = 2'h1,
		CTSL_TX   = 2'h3
	} ctsl_ctl_e;

	typedef struct packed {
		logic        we;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} ctsl_mem_req_s;

	typedef struct packed {
		logic clk;
		logic data;
		logic frame;
	} ctsl_link_s;

endpackage : ctsl_pkg
`default_nettype wire

/* File: logic/ctsl_fifo.sv */
// Byte FIFO between link receiver and frame parser
`timescale 1ns/1ps
`default_nettype none
module ctsl_fifo
	import ctsl_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic      [WIDTH-1:0] o_data
);
	// DEPTH must be a power of two: pointers wrap by overflow
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;

	wire logic full  = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire logic empty = (wr_ptr == rd_ptr);
	wire logic push  = i_valid & ~full;
	wire logic pop   = ~empty & i_ready;

	assign o_ready = ~full;
	assign o_valid = ~empty;
	assign o_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= i_data;
	end

endmodule : ctsl_fifo
`default_nettype wire

/* File: test/ctsl_reader_model.sv */
// Reader model: frames requests, clocks the link, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
`include "ctsl_consts.svh"
module ctsl_reader_model
	import ctsl_pkg::*;
(
	output var  ctsl_link_s o_link,
	input  wire logic       i_tx,
	input  wire logic       i_tx_frame
);
	logic [7:0] rsp[$];
	logic       bad_char;
	logic [9:0] sh;
	int         nbit;

	initial
	begin
		o_link   = '0;
		bad_char = 1'b0;
		nbit     = 0;
		sh       = '0;
	end

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = `CTSL_CRC_INIT;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? ((c >> 1) ^ `CTSL_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc16

	// Sampled mid-bit, half a link period after the tag moves its line
	always @(posedge o_link.clk)
	begin
		if (!i_tx_frame)
			nbit = 0;
		else if (nbit > 0 || !i_tx)
		begin
			sh = {i_tx, sh[9:1]};
			nbit = nbit + 1;
			if (nbit == 10)
			begin
				bad_char = bad_char | !sh[9] | sh[0];
				rsp.push_back(sh[8:1]);
				nbit = 0;
			end
		end
	end

	// Link clock moves only here, so it stands still between transfers
	task automatic tick();
		#80;
		o_link.clk = 1'b1;
		#80;
		o_link.clk = 1'b0;
	endtask : tick

	// One request at a time; clocks on until the reply is over
	task automatic xfer(input logic [7:0] req[$], input logic bad_crc);
		logic [15:0] c;
		logic [9:0]  ch;
		c = ~crc16(req) ^ {15'h0000, bad_crc};
		req.push_back(c[7:0]);
		req.push_back(c[15:8]);
		rsp.delete();
		bad_char = 1'b0;
		o_link.frame = 1'b1;
		foreach (req[i])
		begin
			ch = {1'b1, req[i], 1'b0};
			for (int b = 0; b < 10; b++)
			begin
				o_link.data = ch[b];
				tick();
			end
		end
		o_link.frame = 1'b0;
		for (int n = 0; n < 4 || (i_tx_frame && n < 130); n++)
		begin
			o_link.data = ~o_link.data;
			tick();
		end
	endtask : xfer
endmodule : ctsl_reader_model
`default_nettype wire

/* File: test/ctsl_core_tb_top.sv */
// Testbench for the tag control core
`timescale 1ns/1ps
`default_nettype none
`include "ctsl_consts.svh"
module ctsl_core_tb_top
	import ctsl_pkg::*;
;
	// Arbitrary value, no meaning
	localparam logic [63:0] UID = 64'h0123_4567_89ab_cdef;
	logic          i_clk;
	logic          i_resetn;
	logic          i_field_ok;
	ctsl_link_s    link;
	logic          o_link_tx;
	logic          o_link_tx_frame;
	logic          o_mem_req;
	ctsl_mem_req_s o_mem;
	logic          i_mem_ack = 1'b0;
	logic [31:0]   i_mem_rdata = 32'h0;
	logic [7:0]    rand_id;
	logic [7:0]    id_prev;
	logic [2:0]    rand_st;
	logic [2:0]    o_tag_state;
	logic [7:0]    o_id;
	logic [31:0]   mem [0:255];
	logic [7:0]    big[$];
	ctsl_mem_req_s last_mem;
	int            n_req = 0;
	int            ack_dly;
	int            wait_cnt = 0;
	int            n_fail;
	int            tests_run;

	initial
	begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	ctsl_core #(
		.FIXED_ID_EN(1'b1),
		.SYS_INIT   (32'hffff_ff3a),
		.UNIQUE_ID  (UID),
		.FIFO_DEPTH (8)
	) u_dut (
		.i_clk                   (i_clk),
		.i_resetn                (i_resetn),
		.i_field_ok              (i_field_ok),
		.i_link                  (link),
		.o_link_tx               (o_link_tx),
		.o_link_tx_frame         (o_link_tx_frame),
		.o_mem_req               (o_mem_req),
		.o_mem                   (o_mem),
		.i_mem_ack               (i_mem_ack),
		.i_mem_rdata             (i_mem_rdata),
		.o_tag_state             (o_tag_state),
		.o_tag_session_identifier(o_id)
	);

	// Second tag with the random identifier; listens only
	ctsl_core #(
		.FIXED_ID_EN(1'b0),
		.SYS_INIT   (32'hffff_ffff),
		.UNIQUE_ID  (UID),
		.FIFO_DEPTH (8)
	) u_rand (
		.i_clk                   (i_clk),
		.i_resetn                (i_resetn),
		.i_field_ok              (i_field_ok),
		.i_link                  (link),
		.o_link_tx               (),
		.o_link_tx_frame         (),
		.o_mem_req               (),
		.o_mem                   (),
		.i_mem_ack               (1'b0),
		.i_mem_rdata             (32'h0),
		.o_tag_state             (rand_st),
		.o_tag_session_identifier(rand_id)
	);

	ctsl_reader_model u_reader (
		.o_link    (link),
		.i_tx      (o_link_tx),
		.i_tx_frame(o_link_tx_frame)
	);

	// Memory stand-in; ack delay varies to show the core waits for it
	always @(posedge i_clk)
	begin
		i_mem_ack <= 1'b0;
		if (o_mem_req && !i_mem_ack)
		begin
			if (wait_cnt == 0)
			begin
				n_req    <= n_req + 1;
				last_mem <= o_mem;
			end
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= ack_dly)
			begin
				i_mem_ack   <= 1'b1;
				i_mem_rdata <= mem[o_mem.addr];
				wait_cnt    <= 0;
				if (o_mem.we)
					mem[o_mem.addr] <= o_mem.wdata;
			end
		end
	end

	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask : chk

	task automatic cmd(input logic [7:0] req[$], input int nexp,
		input logic [63:0] exp, input logic [2:0] st,
		input logic bad = 1'b0);
		u_reader.xfer(req, bad);
		repeat (4) @(posedge i_clk);
		#1;
		chk(u_reader.rsp.size(), (nexp > 0) ? nexp + 2 : 0);
		for (int i = 0; i < nexp && i < u_reader.rsp.size(); i++)
			chk(u_reader.rsp[i], exp[8*i +: 8]);
		if (nexp > 0)
			chk(u_reader.crc16(u_reader.rsp), `CTSL_CRC_GOOD);
		chk(u_reader.bad_char, 1'b0);
		chk(o_link_tx_frame, 1'b0);
		chk(o_tag_state, st);
	endtask : cmd

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input int dreq);
		int n0;
		n0 = n_req;
		cmd('{`CTSL_CMD_WRITE, a, d[7:0], d[15:8], d[23:16], d[31:24]},
			0, 0, CTSL_SELECTED);
		chk(n_req - n0, dreq);
		if (dreq > 0)
			chk(last_mem, {1'b1, a, d});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input int dreq);
		int n0;
		n0 = n_req;
		cmd('{`CTSL_CMD_READ, a}, 4, {32'h0, d}, CTSL_SELECTED);
		chk(n_req - n0, dreq);
		if (dreq > 0)
			chk({last_mem.we, last_mem.addr}, {1'b0, a});
	endtask : rd

	initial
	begin
		#800000;
		n_fail++;
		conclude();
	end

	initial
	begin
		i_resetn    = 1'b0;
		i_field_ok  = 1'b1;
		ack_dly     = 1;
		n_fail      = 0;
		tests_run   = 0;
		for (int i = 0; i < 256; i++)
			mem[i] = 32'h1000_0000 + i;
		repeat (8) big.push_back(`CTSL_CMD_WAKE);
		repeat (2) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (6) @(posedge i_clk);
		#1;
		chk(o_tag_state, CTSL_READY);
		chk({o_link_tx, o_link_tx_frame}, 2'b10);
		chk(o_id, 8'h3a);
		id_prev = rand_id;
		@(posedge i_clk);
		#1;
		chk(rand_id != id_prev, 1'b1);
		@(posedge i_clk);
		i_field_ok <= 1'b0;
		repeat (6) @(posedge i_clk);
		#1;
		chk(o_tag_state, CTSL_POWER_OFF);
		cmd('{`CTSL_CMD_WAKE}, 0, 0, CTSL_POWER_OFF);
		@(posedge i_clk);
		i_field_ok <= 1'b1;
		repeat (6) @(posedge i_clk);
		cmd('{`CTSL_CMD_POLL}, 0, 0, CTSL_READY);
		cmd('{`CTSL_CMD_SELECT, 8'h3a}, 0, 0, CTSL_READY);
		cmd('{`CTSL_CMD_WAKE}, 1, 64'h3a, CTSL_INVENTORY);
		chk(rand_st, CTSL_INVENTORY);
		id_prev = rand_id;
		repeat (3) @(posedge i_clk);
		#1;
		chk(rand_id, id_prev);
		cmd('{`CTSL_CMD_WAKE}, 0, 0, CTSL_INVENTORY, 1'b1);
		cmd('{8'h77}, 0, 0, CTSL_INVENTORY);
		cmd(big, 0, 0, CTSL_INVENTORY);
		cmd('{`CTSL_CMD_POLL}, 0, 0, CTSL_INVENTORY);
		cmd('{{4'h5, `CTSL_CMD_ADV_LO}}, 0, 0, CTSL_INVENTORY);
		cmd('{{4'ha, `CTSL_CMD_ADV_LO}}, 1, 64'h3a, CTSL_INVENTORY);
		cmd('{{4'ha, `CTSL_CMD_ADV_LO}}, 0, 0, CTSL_INVENTORY);
		cmd('{`CTSL_CMD_WAKE}, 1, 64'h3a, CTSL_INVENTORY);
		cmd('{{4'ha, `CTSL_CMD_ADV_LO}}, 1, 64'h3a, CTSL_INVENTORY);
		cmd('{`CTSL_CMD_SELECT, 8'h55}, 0, 0, CTSL_INVENTORY);
		cmd('{`CTSL_CMD_SELECT, 8'h3a}, 1, 64'h3a, CTSL_SELECTED);
		cmd('{`CTSL_CMD_POLL}, 0, 0, CTSL_SELECTED);
		cmd('{`CTSL_CMD_WAKE}, 0, 0, CTSL_SELECTED);
		cmd('{`CTSL_CMD_AUTH}, 0, 0, CTSL_SELECTED);
		cmd('{`CTSL_CMD_UID}, 8, UID, CTSL_SELECTED);
		ack_dly = 25;
		rd(8'h0a, 32'h1000_000a, 1);
		ack_dly = 1;
		wr(8'h07, 32'h4433_2211, 1);
		rd(8'h07, 32'h4433_2211, 1);
		wr(8'hff, 32'hfeff_ffff, 0);
		rd(8'hff, 32'hfeff_ff3a, 0);
		wr(8'h07, 32'h0, 0);
		wr(8'h08, 32'h0, 0);
		wr(8'h09, 32'h0, 1);
		wr(8'hff, 32'hffff_ffff, 0);
		rd(8'hff, 32'hfeff_ff3a, 0);
		for (int k = 1; k < 8; k++)
		begin
			wr(8'hff, ~(32'h0100_0000 << k), 0);
			wr(8'h08 + k[7:0], 32'h0, 0);
		end
		rd(8'hff, 32'h00ff_ff3a, 0);
		wr(8'h10, 32'h0, 1);
		rd(8'h07, 32'h4433_2211, 1);
		cmd('{`CTSL_CMD_SELECT, 8'h55}, 0, 0, CTSL_DESELECTED);
		cmd('{`CTSL_CMD_READ, 8'h0a}, 0, 0, CTSL_DESELECTED);
		cmd('{`CTSL_CMD_SELECT, 8'h3a}, 1, 64'h3a, CTSL_SELECTED);
		cmd('{`CTSL_CMD_DONE}, 0, 0, CTSL_DEACTIVATED);
		cmd('{`CTSL_CMD_SELECT, 8'h3a}, 0, 0, CTSL_DEACTIVATED);
		cmd('{`CTSL_CMD_WAKE}, 0, 0, CTSL_DEACTIVATED);
		conclude();
	end
endmodule : ctsl_core_tb_top
`default_nettype wire
